// ==== rtl/sdp_pin_cell.sv ====
`timescale 1ns/10ps
module sdp_pin_cell
   import sdp_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic func_sel,
   input wire logic dir_out,
   input wire logic latch,
   input wire logic engine_out,
   input wire logic engine_drive,
   input wire logic pin_in,
   output logic pin_out,
   output logic pin_oe_n,
   output logic level_reg
);
   logic drive_next;
   logic out_next;

   always_comb begin
      if (func_sel) begin
         // serial data path owns the pin
         drive_next = engine_drive;
         out_next = engine_out;
      end else begin
         // general-purpose use: latch only while direction is output
         drive_next = dir_out;
         out_next = dir_out ? latch : 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_oe_n <= 1'b1;
         pin_out <= 1'b0;
      end else begin
         pin_oe_n <= ~drive_next;
         pin_out <= out_next;
      end
   end

   // level sampled regardless of function or direction
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         level_reg <= 1'b0;
      end else begin
         level_reg <= pin_in;
      end
   end
endmodule // sdp_pin_cell

// ==== rtl/sdp_pkg.sv ====
package sdp_pkg;
   // register indices; byte address is four times the index
   localparam logic [16:0] SDP_IDX_PORT_CTRL = 17'h0704e;
   localparam logic [16:0] SDP_IDX_PRI_SUSP = 17'h0704f;
   localparam logic [16:0] SDP_IDX_SUSP_STAT = 17'h07050;
   localparam int SDP_ADDR_W = 17;
   localparam logic [16:0] SDP_ADDR_PORT_CTRL = 17'(SDP_IDX_PORT_CTRL * 4);
   localparam logic [16:0] SDP_ADDR_PRI_SUSP = 17'(SDP_IDX_PRI_SUSP * 4);
   localparam logic [16:0] SDP_ADDR_SUSP_STAT = 17'(SDP_IDX_SUSP_STAT * 4);

   // port control field positions
   localparam int SDP_SIMO_IN_BIT = 7;
   localparam int SDP_SIMO_OUT_BIT = 6;
   localparam int SDP_SIMO_FUNC_BIT = 5;
   localparam int SDP_SIMO_DIR_BIT = 4;
   localparam int SDP_SOMI_IN_BIT = 3;
   localparam int SDP_SOMI_OUT_BIT = 2;
   localparam int SDP_SOMI_FUNC_BIT = 1;
   localparam int SDP_SOMI_DIR_BIT = 0;
   // writable bits of port control
   localparam logic [7:0] SDP_PORT_WMASK = 8'h77;

   // priority / suspend field positions
   localparam int SDP_PRI_BIT = 6;
   localparam int SDP_SUSP_BIT = 5;
   localparam logic [7:0] SDP_PRI_WMASK = 8'h60;

   // suspend status field positions
   localparam int SDP_STAT_HALT_BIT = 0;
   localparam int SDP_STAT_DRAIN_BIT = 1;
   localparam int SDP_STAT_FROZEN_BIT = 2;

   localparam logic [7:0] SDP_PORT_RESET = 8'h00;
   localparam logic [7:0] SDP_PRI_RESET = 8'h00;

   localparam int SDP_NUM_PINS = 2;
   localparam int SDP_PIN_SIMO = 1;
   localparam int SDP_PIN_SOMI = 0;

   typedef enum logic [2:0] {
      SDP_RUN = 3'b001,
      SDP_DRAIN = 3'b010,
      SDP_FROZEN = 3'b100
   } sdp_susp_state_t;
endpackage

// ==== rtl/sdp_top.sv ====
`timescale 1ns/10ps
// How it works
// [R1] simo readback returns pin level, writes ignored
// [R2] simo latch drives only in output GP mode
// [R3] simo function bit: 0 GP, 1 serial
// [R4] simo direction: 0 input, 1 output
// [R5] somi readback returns pin level, writes ignored
// [R6] somi latch drives only in output GP mode
// [R7] somi function bit: 0 GP, 1 serial
// [R8] somi direction: 0 input, 1 output
// [R9] shift clocking continues with somi GP input
// [R10] priority bit routes request high or low
// [R11] suspend bit acts only during debug halt
// [R12] one setting: finish current transfer, then stop
// [R13] other setting: freeze engine at halt
// [R14] reserved priority bits ignore writes
// [R15] priority 0 high, 1 low
// [R16] suspend 0 drains, 1 freezes at once
// [R17] reset clears all writable bits
module sdp_top
   import sdp_pkg::*;
#(
   parameter int ADDR_W = SDP_ADDR_W
)(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic slave_in_master_out_pin_in,
   output logic slave_in_master_out_pin_out,
   output logic slave_in_master_out_pin_oe_n,
   input wire logic slave_out_master_in_pin_in,
   output logic slave_out_master_in_pin_out,
   output logic slave_out_master_in_pin_oe_n,
   input wire logic engine_simo_out,
   input wire logic engine_simo_drive,
   input wire logic engine_somi_out,
   input wire logic engine_somi_drive,
   output logic engine_simo_in,
   output logic engine_somi_in,
   input wire logic engine_irq,
   input wire logic engine_busy,
   input wire logic debug_halt,
   output logic engine_run,
   output logic shift_clk_enable,
   output logic irq_high,
   output logic irq_low
);
   // decode compares full byte addresses, so narrower buses cannot reach the map
   if (ADDR_W < SDP_ADDR_W || ADDR_W > 32) begin : g_bad_addr_w
      $error("sdp_top: ADDR_W must lie between 17 and 32");
   end

   logic rst_meta_reg;
   logic rst_n;
   logic [7:0] data_pin_port_control_reg;
   logic [7:0] irq_priority_suspend_control_reg;
   sdp_susp_state_t susp_state_reg;
   sdp_susp_state_t susp_state_next;
   logic [SDP_NUM_PINS-1:0] pin_in;
   logic [SDP_NUM_PINS-1:0] pin_out;
   logic [SDP_NUM_PINS-1:0] pin_oe_n;
   logic [SDP_NUM_PINS-1:0] pin_level;
   logic [SDP_NUM_PINS-1:0] pin_func;
   logic [SDP_NUM_PINS-1:0] pin_dir;
   logic [SDP_NUM_PINS-1:0] pin_latch;
   logic [SDP_NUM_PINS-1:0] eng_out;
   logic [SDP_NUM_PINS-1:0] eng_drive;
   logic setup_phase;
   logic access_done;
   logic wr_en;
   logic hit_port;
   logic hit_pri;
   logic hit_stat;
   logic [7:0] wbyte;
   logic [7:0] rd_byte;
   logic [7:0] stat_byte;

   // two-stage release; assertion stays asynchronous
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n <= rst_meta_reg;
      end
   end

   // bus decode
   assign hit_port = (paddr == ADDR_W'(SDP_ADDR_PORT_CTRL));
   assign hit_pri = (paddr == ADDR_W'(SDP_ADDR_PRI_SUSP));
   assign hit_stat = (paddr == ADDR_W'(SDP_ADDR_SUSP_STAT));
   assign setup_phase = psel && !penable;
   assign access_done = psel && penable && pready;
   assign wr_en = access_done && pwrite && pstrb[0];
   // all fields sit in byte lane 0
   assign wbyte = pwdata[7:0];

   // status of the suspend controller, read-only
   always_comb begin
      stat_byte = 8'h00;
      stat_byte[SDP_STAT_HALT_BIT] = debug_halt;
      stat_byte[SDP_STAT_DRAIN_BIT] = (susp_state_reg == SDP_DRAIN);
      stat_byte[SDP_STAT_FROZEN_BIT] = (susp_state_reg == SDP_FROZEN);
   end

   always_comb begin
      rd_byte = 8'h00;
      if (hit_port) begin
         rd_byte = data_pin_port_control_reg;
         rd_byte[SDP_SIMO_IN_BIT] = pin_level[SDP_PIN_SIMO]; // R1
         rd_byte[SDP_SOMI_IN_BIT] = pin_level[SDP_PIN_SOMI]; // R5
      end else if (hit_pri) begin
         // reserved bits read as zero
         rd_byte = irq_priority_suspend_control_reg & SDP_PRI_WMASK; // R14
      end else if (hit_stat) begin
         rd_byte = stat_byte;
      end
   end

   // no wait state: answer in the first access cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pready <= 1'b0;
      end else begin
         pready <= setup_phase;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (setup_phase) begin
         prdata <= pwrite ? 32'h00000000 : {24'h000000, rd_byte};
         // status is read-only, a write to it is refused
         pslverr <= !(hit_port || hit_pri || (hit_stat && !pwrite));
      end else if (access_done) begin
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end
   end

   // readback bits are not storage; they never take write data
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         data_pin_port_control_reg <= SDP_PORT_RESET; // R17
      end else if (wr_en && hit_port) begin
         data_pin_port_control_reg <= wbyte & SDP_PORT_WMASK; // R1 R5
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_priority_suspend_control_reg <= SDP_PRI_RESET; // R17
      end else if (wr_en && hit_pri) begin
         irq_priority_suspend_control_reg <= wbyte & SDP_PRI_WMASK; // R14
      end
   end

   // per-pin field extraction
   assign pin_func[SDP_PIN_SIMO] = data_pin_port_control_reg[SDP_SIMO_FUNC_BIT]; // R3
   assign pin_dir[SDP_PIN_SIMO] = data_pin_port_control_reg[SDP_SIMO_DIR_BIT]; // R4
   assign pin_latch[SDP_PIN_SIMO] = data_pin_port_control_reg[SDP_SIMO_OUT_BIT]; // R2
   assign pin_func[SDP_PIN_SOMI] = data_pin_port_control_reg[SDP_SOMI_FUNC_BIT]; // R7
   assign pin_dir[SDP_PIN_SOMI] = data_pin_port_control_reg[SDP_SOMI_DIR_BIT]; // R8
   assign pin_latch[SDP_PIN_SOMI] = data_pin_port_control_reg[SDP_SOMI_OUT_BIT]; // R6
   assign pin_in[SDP_PIN_SIMO] = slave_in_master_out_pin_in;
   assign pin_in[SDP_PIN_SOMI] = slave_out_master_in_pin_in;
   assign eng_out[SDP_PIN_SIMO] = engine_simo_out;
   assign eng_drive[SDP_PIN_SIMO] = engine_simo_drive;
   assign eng_out[SDP_PIN_SOMI] = engine_somi_out;
   assign eng_drive[SDP_PIN_SOMI] = engine_somi_drive;

   generate
      for (genvar i = 0; i < SDP_NUM_PINS; i++) begin : g_pin
         sdp_pin_cell u_cell (
            .clk(clk),
            .rst_n(rst_n),
            .func_sel(pin_func[i]), // R3 R7
            .dir_out(pin_dir[i]), // R4 R8
            .latch(pin_latch[i]), // R2 R6
            .engine_out(eng_out[i]),
            .engine_drive(eng_drive[i]),
            .pin_in(pin_in[i]),
            .pin_out(pin_out[i]),
            .pin_oe_n(pin_oe_n[i]),
            .level_reg(pin_level[i])
         );
      end
   endgenerate

   assign slave_in_master_out_pin_out = pin_out[SDP_PIN_SIMO];
   assign slave_in_master_out_pin_oe_n = pin_oe_n[SDP_PIN_SIMO];
   assign slave_out_master_in_pin_out = pin_out[SDP_PIN_SOMI];
   assign slave_out_master_in_pin_oe_n = pin_oe_n[SDP_PIN_SOMI];

   // engine always sees pin levels, so receive still shifts in GP mode
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         engine_simo_in <= 1'b0;
         engine_somi_in <= 1'b0;
      end else begin
         engine_simo_in <= pin_in[SDP_PIN_SIMO];
         engine_somi_in <= pin_in[SDP_PIN_SOMI]; // R9
      end
   end

   // debug suspend; bit value only matters while halted
   always_comb begin
      susp_state_next = susp_state_reg;
      unique case (susp_state_reg)
         SDP_RUN: begin
            if (debug_halt) begin // R11
               if (irq_priority_suspend_control_reg[SDP_SUSP_BIT]) begin
                  susp_state_next = SDP_FROZEN; // R13 R16
               end else if (engine_busy) begin
                  susp_state_next = SDP_DRAIN; // R12 R16
               end else begin
                  susp_state_next = SDP_FROZEN; // R12
               end
            end
         end
         SDP_DRAIN: begin
            if (!debug_halt) begin
               susp_state_next = SDP_RUN;
            end else if (!engine_busy) begin
               susp_state_next = SDP_FROZEN; // R12
            end
         end
         SDP_FROZEN: begin
            if (!debug_halt) begin
               susp_state_next = SDP_RUN;
            end
         end
         default: begin
            susp_state_next = SDP_RUN;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         susp_state_reg <= SDP_RUN;
      end else begin
         susp_state_reg <= susp_state_next;
      end
   end

   // run decided from next state so freeze lands on the halt edge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         engine_run <= 1'b1;
      end else begin
         engine_run <= (susp_state_next != SDP_FROZEN); // R13
      end
   end

   // shift clock gated only by suspend, never by pin configuration
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         shift_clk_enable <= 1'b1;
      end else begin
         shift_clk_enable <= (susp_state_next != SDP_FROZEN); // R9
      end
   end

   // request routed to one level only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_high <= 1'b0;
         irq_low <= 1'b0;
      end else begin
         irq_high <= engine_irq && !irq_priority_suspend_control_reg[SDP_PRI_BIT]; // R10 R15
         irq_low <= engine_irq && irq_priority_suspend_control_reg[SDP_PRI_BIT]; // R10 R15
      end
   end
endmodule // sdp_top

// ==== tb/sdp_board_model.sv ====
`timescale 1ns/10ps
module sdp_board_model (
   input wire logic simo_out,
   input wire logic simo_oe_n,
   input wire logic somi_out,
   input wire logic somi_oe_n,
   input wire logic [1:0] ext,
   output logic simo_in,
   output logic somi_in
);
   // board drives a line only while the block has released it
   assign simo_in = simo_oe_n ? ext[1] : simo_out;
   assign somi_in = somi_oe_n ? ext[0] : somi_out;
endmodule // sdp_board_model

// ==== tb/sdp_checker_properties.sv ====
`timescale 1ns/10ps
module sdp_checker (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic slave_in_master_out_pin_in,
   input wire logic slave_in_master_out_pin_oe_n,
   input wire logic slave_out_master_in_pin_in,
   input wire logic slave_out_master_in_pin_oe_n,
   input wire logic engine_simo_in,
   input wire logic engine_somi_in,
   input wire logic engine_irq,
   input wire logic engine_busy,
   input wire logic debug_halt,
   input wire logic engine_run,
   input wire logic shift_clk_enable,
   input wire logic irq_high,
   input wire logic irq_low
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   AST_ACCESS_READY: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   AST_READY_PULSE: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   AST_SIMO_LEVEL: assert property (engine_simo_in == $past(slave_in_master_out_pin_in))
      else $error("simo level not passed on");
   AST_SOMI_LEVEL: assert property (engine_somi_in == $past(slave_out_master_in_pin_in))
      else $error("somi level not passed on");
   AST_IRQ_ROUTED: assert property ($past(engine_irq) |-> irq_high ^ irq_low)
      else $error("request not on exactly one level");
   AST_IRQ_QUIET: assert property (!$past(engine_irq) |-> !irq_high && !irq_low)
      else $error("request without cause");
   AST_RUN_NO_HALT: assert property (!$past(debug_halt) |-> engine_run)
      else $error("engine stopped without halt");
   AST_STOP_CAUSE: assert property ($fell(engine_run) |-> $past(debug_halt))
      else $error("engine stop not caused by halt");
   AST_DRAIN_STOP: assert property ((debug_halt && !engine_busy) [*3] |=> !engine_run)
      else $error("engine runs on after transfer end");
   AST_SHIFT_CLK: assert property (shift_clk_enable == engine_run)
      else $error("shift clock enable differs from run");
   AST_RESET_PINS: assert property ($rose(arst_n) |->
      slave_in_master_out_pin_oe_n && slave_out_master_in_pin_oe_n)
      else $error("pin driven out of reset");
   cover property (pslverr);
   cover property ($fell(engine_run));
   cover property (irq_low);
endmodule // sdp_checker

bind sdp_top sdp_checker chk_u (.clk, .arst_n, .psel, .penable, .pready, .pslverr,
   .slave_in_master_out_pin_in, .slave_in_master_out_pin_oe_n, .slave_out_master_in_pin_in,
   .slave_out_master_in_pin_oe_n, .engine_simo_in, .engine_somi_in, .engine_irq,
   .engine_busy, .debug_halt, .engine_run, .shift_clk_enable, .irq_high, .irq_low);

// ==== tb/sdp_top_tb.sv ====
`timescale 1ns/10ps
module sdp_top_tb;
   import sdp_pkg::*;
   typedef struct packed {
      logic [7:0] wv;
      logic [1:0] ext;
      logic [7:0] rd;
      logic [1:0] oe_n;
      logic [1:0] out;
   } sdp_row_t;
   sdp_row_t rows [5] = '{'{8'h50, 2'h0, 8'hd0, 2'h1, 2'h2}, '{8'h05, 2'h2, 8'h8d, 2'h2, 2'h1},
      '{8'h10, 2'h3, 8'h18, 2'h1, 2'h0}, '{8'hcc, 2'h0, 8'h44, 2'h3, 2'h0},
      '{8'h77, 2'h1, 8'h7f, 2'h3, 2'h0}};
   logic clk = 1'h0;
   logic arst_n = 1'h0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [16:0] paddr = 17'h0;
   logic [31:0] pwdata = 32'h0;
   logic [1:0] ext = 2'h0;
   logic eso = 1'h0, esd = 1'h0, emo = 1'h0, emd = 1'h0;
   logic eirq = 1'h0, ebusy = 1'h0, dhalt = 1'h0;
   logic [31:0] prdata, r;
   logic pready, pslverr, err, esi, emi, run, sce, irqh, irql;
   logic simo_in, simo_out, simo_oe_n, somi_in, somi_out, somi_oe_n;
   int miscompares = 0;
   int n_tests = 0;

   sdp_top dut_u (.clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf),
      .prdata, .pready, .pslverr, .slave_in_master_out_pin_in(simo_in),
      .slave_in_master_out_pin_out(simo_out), .slave_in_master_out_pin_oe_n(simo_oe_n),
      .slave_out_master_in_pin_in(somi_in), .slave_out_master_in_pin_out(somi_out),
      .slave_out_master_in_pin_oe_n(somi_oe_n), .engine_simo_out(eso),
      .engine_simo_drive(esd), .engine_somi_out(emo), .engine_somi_drive(emd),
      .engine_simo_in(esi), .engine_somi_in(emi), .engine_irq(eirq), .engine_busy(ebusy),
      .debug_halt(dhalt), .engine_run(run), .shift_clk_enable(sce), .irq_high(irqh),
      .irq_low(irql));
   sdp_board_model brd_u (.simo_out, .simo_oe_n, .somi_out, .somi_oe_n, .ext, .simo_in,
      .somi_in);

   initial begin
      forever #5 clk = ~clk;
   end

   task automatic close_out();
      if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask

   // entered just after a rising edge; leaves one idle cycle behind
   task automatic apb(input logic w, input logic [16:0] a, input logic [7:0] d);
      int n;
      n = 0;
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'h1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      if (n >= 20) miscompares++;
      r = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge clk);
   endtask

   initial begin
      repeat (5000) @(posedge clk);
      miscompares++;
      close_out();
   end

   initial begin
      repeat (12) @(posedge clk);
      arst_n <= 1'h1;
      repeat (3) @(posedge clk);
      apb(1'h0, SDP_ADDR_PORT_CTRL, 8'h0);
      chk(r, 32'h0);
      apb(1'h0, SDP_ADDR_PRI_SUSP, 8'h0);
      chk(r, 32'h0);
      chk(32'({simo_oe_n, somi_oe_n, sce}), 32'h7);
      apb(1'h0, 17'h0, 8'h0);
      chk(32'(err), 32'h1);
      foreach (rows[i]) begin
         ext <= rows[i].ext;
         apb(1'h1, SDP_ADDR_PORT_CTRL, rows[i].wv);
         repeat (4) @(posedge clk);
         chk(32'({simo_oe_n, somi_oe_n}), 32'(rows[i].oe_n));
         chk(32'({simo_out, somi_out} & ~rows[i].oe_n), 32'(rows[i].out));
         apb(1'h0, SDP_ADDR_PORT_CTRL, 8'h0);
         chk(r, {24'h0, rows[i].rd});
      end
      apb(1'h1, SDP_ADDR_PRI_SUSP, 8'hff);
      apb(1'h0, SDP_ADDR_PRI_SUSP, 8'h0);
      chk(r, 32'h60);
      eirq <= 1'h1;
      repeat (3) @(posedge clk);
      chk(32'({irqh, irql}), 32'h1);
      apb(1'h1, SDP_ADDR_PRI_SUSP, 8'h00);
      repeat (2) @(posedge clk);
      chk(32'({irqh, irql}), 32'h2);
      eirq <= 1'h0;
      // serial function hands both pins to the engine
      apb(1'h1, SDP_ADDR_PORT_CTRL, 8'h22);
      eso <= 1'h1;
      esd <= 1'h1;
      emd <= 1'h1;
      repeat (4) @(posedge clk);
      chk(32'({simo_oe_n, somi_oe_n, simo_out, somi_out, esi, emi}), 32'h0a);
      esd <= 1'h0;
      emd <= 1'h0;
      ebusy <= 1'h1;
      dhalt <= 1'h1;
      repeat (4) @(posedge clk);
      chk(32'(run), 32'h1);
      ebusy <= 1'h0;
      repeat (4) @(posedge clk);
      chk(32'({run, sce}), 32'h0);
      // status: halt seen and engine frozen
      apb(1'h0, SDP_ADDR_SUSP_STAT, 8'h0);
      chk(r, 32'h5);
      apb(1'h1, SDP_ADDR_SUSP_STAT, 8'hff);
      chk(32'(err), 32'h1);
      dhalt <= 1'h0;
      apb(1'h1, SDP_ADDR_PRI_SUSP, 8'h20);
      ebusy <= 1'h1;
      repeat (3) @(posedge clk);
      chk(32'(run), 32'h1);
      dhalt <= 1'h1;
      repeat (3) @(posedge clk);
      chk(32'(run), 32'h0);
      dhalt <= 1'h0;
      ebusy <= 1'h0;
      repeat (3) @(posedge clk);
      chk(32'(run), 32'h1);
      // mid-run reset; quiet lines so the delayed level checks stay consistent
      apb(1'h1, SDP_ADDR_PORT_CTRL, 8'h50);
      ext <= 2'h0;
      repeat (2) @(posedge clk);
      arst_n <= 1'h0;
      @(posedge clk);
      chk(32'({simo_oe_n, somi_oe_n, run}), 32'h7);
      arst_n <= 1'h1;
      repeat (3) @(posedge clk);
      apb(1'h0, SDP_ADDR_PORT_CTRL, 8'h0);
      chk(r, 32'h0);
      close_out();
   end
endmodule // sdp_top_tb
